// >>> design/asbc_pkg.sv
// package: register map, field positions, modes and timing constants of the serial bus channel
package asbc_pkg;
    // documented register addresses (device side)
    localparam logic [15:0] MODE_CTRL_ADDR = 16'hff60;
    localparam logic [15:0] BUS_CTRL_ADDR = 16'hff61;
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] BUS_CTRL_RESET = 8'h00;
    // serial_mode_control fields
    localparam int CHAN_EN_BIT = 7;
    localparam int ADDR_MATCH_BIT = 6;
    localparam int WAKEUP_BIT = 5;
    localparam int MODE_HI_BIT = 4;
    localparam int MODE_LO_BIT = 2;
    localparam int CLK_HI_BIT = 1;
    localparam int CLK_LO_BIT = 0;
    // serial_bus_control fields
    localparam int BUSY_OE_BIT = 7;
    localparam int CMD_DET_BIT = 3;
    localparam int REL_DET_BIT = 2;
    localparam int CMD_TRIG_BIT = 1;
    localparam int REL_TRIG_BIT = 0;
    // clock select codes (hi bit, lo bit)
    localparam logic [1:0] CLK_TIMER = 2'h2;
    localparam logic [1:0] CLK_TCS = 2'h3;
    localparam int XFER_BITS = 8;
    localparam logic [7:0] ALL_ONES = 8'hff;
    // host APB register offsets
    localparam logic [7:0] H_CTRL_OFS = 8'h00;
    localparam logic [7:0] H_TXD_OFS = 8'h04;
    localparam logic [7:0] H_RXD_OFS = 8'h08;
    localparam logic [7:0] H_STAT_OFS = 8'h0c;
    localparam logic [7:0] H_IEN_OFS = 8'h10;
    localparam logic [7:0] H_ICLR_OFS = 8'h14;
    // host control bits
    localparam int H_GO_BIT = 0;
    localparam int H_REL_BIT = 1;
    localparam int H_CMD_BIT = 2;
    localparam int H_DIV_LSB = 8;
    localparam logic [7:0] H_DIV_RESET = 8'h04;
    // host status/event bits
    localparam int EV_DONE = 0;
    localparam int EV_READY = 1;
    typedef enum logic [1:0] {ASBC_IDLE, ASBC_LOW, ASBC_HIGH, ASBC_STOP} asbc_hstate_t;
endpackage

// >>> design/asbc_if.sv
// interface: shared serial clock and open-drain data lines between the two ends
interface asbc_if;
    logic sck;
    logic sda_a_o;
    logic sda_a_oe;
    logic sda_b_o;
    logic sda_b_oe;
    logic dev_a_o;
    logic dev_a_oe;
    logic dev_b_o;
    logic dev_b_oe;
    logic line_a;
    logic line_b;
    // open-drain wired-and with pull-up
    assign line_a = ~((sda_a_oe & ~sda_a_o) | (dev_a_oe & ~dev_a_o));
    assign line_b = ~((sda_b_oe & ~sda_b_o) | (dev_b_oe & ~dev_b_o));
    modport host (output sck, output sda_a_o, output sda_a_oe, output sda_b_o, output sda_b_oe,
                  input line_a, input line_b);
    modport dev (input sck, output dev_a_o, output dev_a_oe, output dev_b_o, output dev_b_oe,
                 input line_a, input line_b);
endinterface

// >>> design/asbc_dev.sv
// device end: serial channel control logic with its two byte-wide control registers
// Contract
// - write shift register starts transfer when idle
// - enable after write does not start
// - wakeup keeps open-drain driver off
// - write while busy waits for ready
// - stop after 8 bits, set done
// - select slave by address after release
// - without wakeup, software uses commands
// - busy held until next falling edge
// - software primes latches and release once
// - master reads data pin for ready
// - clock select picks serial clock source
// - mode field selects bus and pin
// - interrupt per transfer or address match
// - software keeps wakeup zero in 2-wire
// - match flag compares address, zero disabled
// - enable bit stops or runs channel
// - release trigger sets latch, self-clears
// - unused data pin stays port pin
//
// Added by the designer: the byte-wide register port (reg_addr, reg_wr).
module asbc_dev
    import asbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    asbc_if.dev bus,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] sr_wdata,
    input wire logic sr_wr,
    output logic [7:0] shift_register,
    input wire logic [7:0] slave_address_reg,
    input wire logic busy_clear,
    input wire logic port_latch_a,
    input wire logic port_latch_b,
    input wire logic pin_direction_a,
    input wire logic pin_direction_b,
    input wire logic eight_bit_timer_output,
    input wire logic timer_clock_select,
    output logic transfer_interrupt,
    output logic sck_out
);
    typedef struct packed {
        logic [2:0] sck_s;
        logic [1:0] a_s;
        logic [1:0] b_s;
        logic [7:0] mode;
        logic [7:0] bctl;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic running;
        logic pending;
        logic so_latch;
        logic busy;
        logic busy_clr_req;
        logic addr_phase;
        logic irq;
        logic [7:0] rdata;
        logic a_o;
        logic a_oe;
        logic b_o;
        logic b_oe;
        logic sck_int;
        logic sck_src_q;
    } asbc_dev_t;
    asbc_dev_t s_q, s_d;
    logic enabled, sck_fall, sck_rise, data_in, use_b, bus_mode, start_ok, match, own_drive;
    logic [1:0] clk_sel;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        enabled = s_q.mode[CHAN_EN_BIT];
        clk_sel = s_q.mode[CLK_HI_BIT:CLK_LO_BIT];
        bus_mode = s_q.mode[MODE_HI_BIT];
        use_b = ~s_q.mode[MODE_LO_BIT];
        unique case (clk_sel)
            CLK_TIMER: s_d.sck_int = eight_bit_timer_output;
            CLK_TCS: s_d.sck_int = timer_clock_select;
            default: s_d.sck_int = s_q.sck_s[1];
        endcase
        s_d.sck_src_q = s_q.sck_int;
        s_d.sck_s = {s_q.sck_s[1], s_q.sck_s[0], bus.sck};
        s_d.a_s = {s_q.a_s[0], bus.line_a};
        s_d.b_s = {s_q.b_s[0], bus.line_b};
        sck_fall = s_q.sck_src_q & ~s_q.sck_int;
        sck_rise = ~s_q.sck_src_q & s_q.sck_int;
        data_in = use_b ? s_q.b_s[1] : s_q.a_s[1];
        // match flag, forced low while disabled
        match = enabled && (slave_address_reg == s_q.sr);
        start_ok = enabled && !s_q.running && s_q.sck_int;
        // own low drive must not be mistaken for a busy partner
        own_drive = use_b ? s_q.b_oe : s_q.a_oe;
        if (!enabled) begin
            s_d.running = 1'b0;
            s_d.pending = 1'b0;
            s_d.bctl[REL_TRIG_BIT] = 1'b0;
            s_d.bctl[CMD_TRIG_BIT] = 1'b0;
        end
        if (reg_wr && reg_addr == MODE_CTRL_ADDR) begin
            s_d.mode = {reg_wdata[7], 1'b0, reg_wdata[5:0]};
        end
        if (reg_wr && reg_addr == BUS_CTRL_ADDR) begin
            s_d.bctl = reg_wdata;
        end
        // release trigger sets latch then clears
        if (enabled && s_q.bctl[REL_TRIG_BIT]) begin
            s_d.so_latch = 1'b1;
            s_d.bctl[REL_TRIG_BIT] = 1'b0;
            s_d.bctl[REL_DET_BIT] = 1'b1;
            s_d.bctl[CMD_DET_BIT] = 1'b0;
            s_d.addr_phase = 1'b1;
        end
        // command trigger clears latch then clears
        if (enabled && s_q.bctl[CMD_TRIG_BIT]) begin
            s_d.so_latch = 1'b0;
            s_d.bctl[CMD_TRIG_BIT] = 1'b0;
            s_d.bctl[CMD_DET_BIT] = 1'b1;
        end
        // a write while disabled never arms a start
        if (sr_wr) begin
            s_d.sr = sr_wdata;
            s_d.so_latch = sr_wdata[7];
            s_d.pending = enabled;
        end
        // deferred start waits on busy clear and ready
        if (s_q.pending && !sr_wr && start_ok && !s_q.busy && (data_in || own_drive)) begin
            s_d.pending = 1'b0;
            s_d.running = 1'b1;
            s_d.cnt = 4'h0;
        end
        // busy clear takes effect on next falling edge
        if (busy_clear) begin
            s_d.busy_clr_req = 1'b1;
        end
        if (s_q.running && sck_rise) begin
            s_d.sr = {s_q.sr[6:0], data_in};
            s_d.cnt = s_q.cnt + 4'h1;
            // stop after eight bits, raise done
            // ends on the 8th rise: the master leaves the clock high afterwards
            if (s_q.cnt == 4'(XFER_BITS - 1)) begin
                s_d.running = 1'b0;
                // interrupt per transfer or on address match
                if (!s_q.mode[WAKEUP_BIT] || !bus_mode) begin
                    s_d.irq = 1'b1;
                end else if (s_q.addr_phase && slave_address_reg == {s_q.sr[6:0], data_in}) begin
                    s_d.irq = 1'b1;
                end
                s_d.addr_phase = 1'b0;
                s_d.bctl[REL_DET_BIT] = 1'b0;
                s_d.busy = s_q.bctl[BUSY_OE_BIT] & bus_mode;
            end
        end
        if (s_q.running && sck_fall) begin
            s_d.so_latch = s_q.sr[7];
        end
        if (sck_fall && s_q.busy_clr_req) begin
            s_d.busy = 1'b0;
            s_d.busy_clr_req = 1'b0;
        end
        // set wins over the register clear of the flag
        if (reg_wr && reg_addr == MODE_CTRL_ADDR && reg_wdata[CHAN_EN_BIT] == 1'b0) begin
            s_d.irq = s_d.irq & s_q.running;
        end
        // wakeup keeps the open-drain driver off
        s_d.a_oe = 1'b0;
        s_d.b_oe = 1'b0;
        s_d.a_o = 1'b1;
        s_d.b_o = 1'b1;
        if (enabled && s_q.mode[MODE_HI_BIT]) begin
            if (use_b) begin
                s_d.b_oe = !(s_q.mode[WAKEUP_BIT] && bus_mode) && (!s_q.so_latch || s_q.busy);
                s_d.b_o = 1'b0;
                // the other pin stays a port pin
                s_d.a_oe = pin_direction_a;
                s_d.a_o = port_latch_a;
            end else begin
                s_d.a_oe = !(s_q.mode[WAKEUP_BIT] && bus_mode) && (!s_q.so_latch || s_q.busy);
                s_d.a_o = 1'b0;
                s_d.b_oe = pin_direction_b;
                s_d.b_o = port_latch_b;
            end
        end else begin
            s_d.a_oe = pin_direction_a;
            s_d.a_o = port_latch_a;
            s_d.b_oe = pin_direction_b;
            s_d.b_o = port_latch_b;
        end
        unique case (reg_addr)
            MODE_CTRL_ADDR: s_d.rdata = {s_q.mode[7], match, s_q.mode[5:0]};
            BUS_CTRL_ADDR: s_d.rdata = s_q.bctl;
            default: s_d.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.mode <= MODE_CTRL_RESET;
            s_q.bctl <= BUS_CTRL_RESET;
            s_q.sck_s <= 3'h7;
            s_q.sck_int <= 1'b1;
            s_q.sck_src_q <= 1'b1;
            s_q.a_s <= 2'h3;
            s_q.b_s <= 2'h3;
            s_q.a_o <= 1'b1;
            s_q.b_o <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign shift_register = s_q.sr;
    assign transfer_interrupt = s_q.irq;
    assign sck_out = s_q.sck_int;
    assign bus.dev_a_o = s_q.a_o;
    assign bus.dev_a_oe = s_q.a_oe;
    assign bus.dev_b_o = s_q.b_o;
    assign bus.dev_b_oe = s_q.b_oe;
endmodule

// >>> design/asbc_host.sv
// host end: APB-controlled master that clocks bytes over the serial bus
module asbc_host
    import asbc_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    asbc_if.host bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);
    typedef struct packed {
        asbc_hstate_t st;
        logic [7:0] div;
        logic [7:0] dcnt;
        logic [7:0] txd;
        logic [7:0] rxd;
        logic [3:0] bits;
        logic [1:0] stat;
        logic [1:0] ien;
        logic [1:0] a_s;
        logic sck;
        logic sda;
        logic rdy_q;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } asbc_host_t;
    asbc_host_t h_q, h_d;
    logic acc, wr, tick, go, ready_rise;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        h_d = h_q;
        acc = psel && penable && !h_q.pready;
        wr = acc && pwrite;
        tick = (h_q.dcnt == 8'h00);
        h_d.dcnt = tick ? h_q.div : h_q.dcnt - 8'h01;
        h_d.a_s = {h_q.a_s[0], bus.line_a};
        go = 1'b0;
        h_d.pready = acc;
        h_d.pslverr = 1'b0;
        h_d.prdata = 32'h0;
        // ready seen as data line back high
        h_d.rdy_q = h_q.a_s[1];
        ready_rise = h_q.a_s[1] && !h_q.rdy_q && h_q.st == ASBC_IDLE;
        if (ready_rise) begin
            h_d.stat[EV_READY] = 1'b1;
        end
        if (wr) begin
            unique case (paddr)
                H_CTRL_OFS: begin
                    go = pwdata[H_GO_BIT];
                    h_d.div = pwdata[H_DIV_LSB +: 8];
                    if (pwdata[H_REL_BIT]) begin
                        h_d.sda = 1'b1;
                    end
                    if (pwdata[H_CMD_BIT]) begin
                        h_d.sda = 1'b0;
                    end
                end
                H_TXD_OFS: h_d.txd = pwdata[7:0];
                H_IEN_OFS: h_d.ien = pwdata[1:0];
                H_ICLR_OFS: h_d.stat = h_q.stat & ~pwdata[1:0];
                default: h_d.pslverr = 1'b1;
            endcase
        end else if (acc) begin
            unique case (paddr)
                H_CTRL_OFS: h_d.prdata = {16'h0, h_q.div, 7'h0, h_q.st != ASBC_IDLE};
                H_TXD_OFS: h_d.prdata = {24'h0, h_q.txd};
                H_RXD_OFS: h_d.prdata = {24'h0, h_q.rxd};
                H_STAT_OFS: h_d.prdata = {30'h0, h_q.stat};
                H_IEN_OFS: h_d.prdata = {30'h0, h_q.ien};
                H_ICLR_OFS: h_d.prdata = 32'h0;
                default: h_d.pslverr = 1'b1;
            endcase
        end
        // msb-first byte, bus shifts on falling, samples on rising
        unique case (h_q.st)
            ASBC_IDLE: begin
                if (go) begin
                    h_d.st = ASBC_LOW;
                    h_d.bits = 4'h0;
                end
            end
            ASBC_LOW: begin
                if (tick) begin
                    h_d.sck = 1'b0;
                    h_d.sda = h_q.txd[7];
                    h_d.st = ASBC_HIGH;
                end
            end
            ASBC_HIGH: begin
                if (tick) begin
                    h_d.sck = 1'b1;
                    h_d.rxd = {h_q.rxd[6:0], h_q.a_s[1]};
                    h_d.txd = {h_q.txd[6:0], 1'b1};
                    h_d.bits = h_q.bits + 4'h1;
                    h_d.st = (h_q.bits == 4'(XFER_BITS - 1)) ? ASBC_STOP : ASBC_LOW;
                end
            end
            ASBC_STOP: begin
                h_d.st = ASBC_IDLE;
                h_d.stat[EV_DONE] = 1'b1;
            end
        endcase
        h_d.irq = |(h_d.stat & h_q.ien);
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            h_q <= '0;
            h_q.div <= H_DIV_RESET;
            h_q.sck <= 1'b1;
            h_q.sda <= 1'b1;
            h_q.a_s <= 2'h3;
            h_q.rdy_q <= 1'b1;
        end else begin
            h_q <= h_d;
        end
    end

    assign prdata = h_q.prdata;
    assign pready = h_q.pready;
    assign pslverr = h_q.pslverr;
    assign irq = h_q.irq;
    assign bus.sck = h_q.sck;
    assign bus.sda_a_o = h_q.sda;
    assign bus.sda_a_oe = ~h_q.sda;
    assign bus.sda_b_o = 1'b1;
    assign bus.sda_b_oe = 1'b0;
endmodule

// >>> testbench/asbc_asserts.sv
// checker: serial clock framing, reset release and host bus handshake
module asbc_asserts (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic sck,
    input wire logic sda_a_oe,
    input wire logic sda_b_oe,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////
    // half period is the divider the bench programs (7) plus one
    sequence low_phase;
        !sck [*8] ##1 sck;
    endsequence
    sequence high_phase;
        sck [*8];
    endsequence
    sequence bus_taken;
        psel && penable && !pready;
    endsequence
    a_sck_low: assert property ($fell(sck) |-> low_phase)
        else $error("clock low phase wrong");
    a_sck_high: assert property ($rose(sck) |-> high_phase)
        else $error("clock high phase short");
    // reset must be seen even while disable is active
    a_sck_reset: assert property (disable iff (1'b0) !rstn |=> sck)
        else $error("clock not idle high in reset");
    a_host_release: assert property (disable iff (1'b0) !rstn |=> !sda_a_oe && !sda_b_oe)
        else $error("host drives data in reset");
    a_ready_answer: assert property (bus_taken |=> pready)
        else $error("ready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("ready without access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule

// >>> testbench/asbc_tb.sv
// testbench: host and device ends joined over the serial bus
module asbc_tb
    import asbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, x; logic err;} asbc_row_t;
    asbc_row_t rows [5] = '{
        '{1'b0, H_CTRL_OFS, 32'h0, 32'hff01, 32'h0400, 1'b0},
        '{1'b0, H_STAT_OFS, 32'h0, 32'h3, 32'h0, 1'b0},
        '{1'b1, H_IEN_OFS, 32'h1, 32'h0, 32'h0, 1'b0},
        '{1'b0, H_IEN_OFS, 32'h0, 32'h3, 32'h1, 1'b0},
        '{1'b0, 8'h20, 32'h0, 32'h0, 32'h0, 1'b1}};
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq, transfer_interrupt, sck_out;
    logic [15:0] reg_addr = 16'h0;
    logic reg_wr = 1'b0, sr_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00, sr_wdata = 8'h00, reg_rdata, shift_register;
    logic lat_a = 1'b0, lat_b = 1'b0, dir_b = 1'b1, tmr_clk = 1'b0, tcs_clk = 1'b0;
    int n_errors = 0, total_checks = 0;
    asbc_if bus_if ();
    always #25 mclk = ~mclk;
    asbc_host asbc_host_inst (.mclk(mclk), .rstn(rstn), .bus(bus_if), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    // slave address fixed: the mismatch case sends a different byte
    asbc_dev asbc_dev_inst (.mclk(mclk), .rstn(rstn), .bus(bus_if), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sr_wdata(sr_wdata),
        .sr_wr(sr_wr), .shift_register(shift_register), .slave_address_reg(8'ha5),
        .busy_clear(1'b0), .port_latch_a(lat_a), .port_latch_b(lat_b), .pin_direction_a(1'b1),
        .pin_direction_b(dir_b), .eight_bit_timer_output(tmr_clk), .timer_clock_select(tcs_clk),
        .transfer_interrupt(transfer_interrupt), .sck_out(sck_out));
    asbc_asserts asbc_asserts_inst (.mclk(mclk), .rstn(rstn), .sck(bus_if.sck),
        .sda_a_oe(bus_if.sda_a_oe), .sda_b_oe(bus_if.sda_b_oe), .psel(psel),
        .penable(penable), .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // request held until the rising edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_errors++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic dw(input logic s, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        sr_wdata <= d;
        reg_wr <= !s;
        sr_wr <= s;
        @(posedge mclk);
        reg_wr <= 1'b0;
        sr_wr <= 1'b0;
    endtask
    task automatic settle;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic dr(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        settle();
        v = reg_rdata;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        logic [31:0] r;
        logic e;
        int n;
        n = 0;
        apb(1'b1, H_ICLR_OFS, 32'h3, r, e);
        apb(1'b1, H_TXD_OFS, 32'(tx), r, e);
        apb(1'b1, H_CTRL_OFS, 32'h0701, r, e);
        do begin
            apb(1'b0, H_STAT_OFS, 32'h0, r, e);
            n++;
        end while (r[EV_DONE] !== 1'b1 && n < 100);
        apb(1'b0, H_RXD_OFS, 32'h0, r, e);
        rx = r[7:0];
    endtask
    ////////////////////////////////////////
    initial begin
        #1_000_000;
        n_errors++;
        wrap_up();
    end
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] v;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        repeat (2) @(posedge mclk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d, r, e);
            chk(r & rows[i].m, rows[i].x);
            chk(32'(e), 32'(rows[i].err));
        end
        dr(MODE_CTRL_ADDR, v);
        chk(32'(v), 32'(MODE_CTRL_RESET));
        dr(BUS_CTRL_ADDR, v);
        chk(32'(v), 32'(BUS_CTRL_RESET));
        dw(1'b0, MODE_CTRL_ADDR, 8'h94);
        @(posedge mclk);
        lat_a <= 1'b1;
        lat_b <= 1'b1;
        dw(1'b0, BUS_CTRL_ADDR, 8'h01);
        @(posedge mclk);
        lat_a <= 1'b0;
        lat_b <= 1'b0;
        settle();
        chk(32'(bus_if.line_a), 32'h1);
        dr(BUS_CTRL_ADDR, v);
        chk(32'(v[REL_TRIG_BIT]), 32'h0);
        dw(1'b0, BUS_CTRL_ADDR, 8'h02);
        settle();
        chk(32'(bus_if.line_a), 32'h0);
        dr(BUS_CTRL_ADDR, v);
        chk(32'(v[CMD_TRIG_BIT]), 32'h0);
        dw(1'b0, BUS_CTRL_ADDR, 8'h01);
        for (int b = 1; b >= 0; b--) begin
            @(posedge mclk);
            dir_b <= 1'b1;
            lat_b <= b[0];
            settle();
            chk(32'(bus_if.line_b), 32'(b[0]));
        end
        dir_b <= 1'b1;
        dw(1'b1, 16'h0, ALL_ONES);
        xfer(8'ha5, v);
        chk(32'(shift_register), 32'ha5);
        chk(32'(transfer_interrupt), 32'h1);
        chk(32'(irq), 32'h1);
        dr(MODE_CTRL_ADDR, v);
        chk(32'(v), 32'hd4);
        apb(1'b1, H_ICLR_OFS, 32'h3, r, e);
        settle();
        chk(32'(irq), 32'h0);
        dw(1'b1, 16'h0, 8'h3c);
        xfer(ALL_ONES, v);
        chk(32'(v), 32'h3c);
        apb(1'b1, H_IEN_OFS, 32'h0, r, e);
        settle();
        chk(32'(irq), 32'h0);
        apb(1'b0, H_STAT_OFS, 32'h0, r, e);
        chk(32'(r[EV_DONE]), 32'h1);
        dw(1'b0, MODE_CTRL_ADDR, 8'h00);
        settle();
        chk(32'(transfer_interrupt), 32'h0);
        dr(MODE_CTRL_ADDR, v);
        chk(32'(v), 32'h00);
        dw(1'b1, 16'h0, 8'h3c);
        dw(1'b0, MODE_CTRL_ADDR, 8'h94);
        xfer(ALL_ONES, v);
        chk(32'(transfer_interrupt), 32'h0);
        // zero in the shift register proves the driver stays off
        for (int k = 0; k < 2; k++) begin
            dw(1'b0, MODE_CTRL_ADDR, 8'h00);
            dw(1'b0, MODE_CTRL_ADDR, 8'hb4);
            dw(1'b0, BUS_CTRL_ADDR, 8'h01);
            dw(1'b1, 16'h0, 8'h00);
            apb(1'b1, H_CTRL_OFS, 32'h0702, r, e);
            apb(1'b1, H_CTRL_OFS, 32'h0704, r, e);
            xfer(k ? 8'h5a : 8'ha5, v);
            chk(32'(transfer_interrupt), 32'(k == 0));
        end
        for (int c = 2; c < 4; c++) begin
            dw(1'b0, MODE_CTRL_ADDR, 8'h94 | 8'(c));
            for (int b = 0; b < 2; b++) begin
                @(posedge mclk);
                tmr_clk <= b[0];
                tcs_clk <= !b[0];
                settle();
                chk(32'(sck_out), 32'((c == 2) ? b[0] : !b[0]));
            end
        end
        wrap_up();
    end
endmodule
